//--- hw/strap_pkg.sv
// package: constants and carrier types for the strap sampler
package strap_pkg;
	localparam int CLK_MHZ = 100;
	// sampling delay after reset release, in nanoseconds
	localparam int SAMPLE_DELAY_NS = 1500;
	localparam int SAMPLE_CYCLES = (SAMPLE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
	localparam int NUM_STRAPS = 8;
	localparam int BOOT_BIT = 0;
	localparam int SPREAD_BIT = 5;
	localparam int SIXTH_BIT = 6;
	localparam logic [NUM_STRAPS-1:0] STRAP_RESET = 8'h00;
	localparam logic [NUM_STRAPS-1:0] SAMPLED_MASK = 8'h61;
	localparam logic [15:0] WB_ADDR_CTRL = 16'h0000;
	localparam logic [15:0] WB_ADDR_STATUS = 16'h0004;
	localparam logic [15:0] WB_ADDR_DEBUG = 16'h0008;

	typedef struct packed {
		logic spread_enable;
		logic boot_hold;
		logic sixth_ok;
		logic test_port_ok;
		logic factory_test;
		logic sampled;
	} strap_cfg_t;

	typedef struct packed {
		logic [NUM_STRAPS-1:0] pin_o;
		logic [NUM_STRAPS-1:0] pin_oe;
	} strap_drive_t;
endpackage : strap_pkg

//--- hw/strap_delay.sv
// module: counts the settle time from reset release to the sample instant
`timescale 1ns/1ps
module strap_delay (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic fire_o,
	output logic done_o
);
	import strap_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic done_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else if (!done_reg) begin
			cnt_reg <= cnt_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
		end else if (fire_o) begin
			done_reg <= 1'b1;
		end
	end

	assign fire_o = !done_reg && (cnt_reg == SAMPLE_LAST);
	assign done_o = done_reg;
endmodule : strap_delay

//--- hw/reset_strap_sampler.sv
// module: strap capture 1.5 us after reset release, then debug drive and wishbone regs
// How it works
// - during chip reset every strap pin is left undriven
// - straps are sampled 1.5 us after chip reset is released
// - sampled spread strap 0 disables spreading, 1 uses flash settings
// - strap pins may be driven for debug only after sampling
// - sampled boot strap 1 stays in boot, 0 loads main application
`timescale 1ns/1ps
module reset_strap_sampler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_i,
	output logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_o,
	output logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_oe,
	input wire logic test_port_reset_n_i,
	input wire logic factory_test_enable_i,
	output logic spread_enable_o,
	output logic boot_hold_o,
	output logic straps_valid_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import strap_pkg::*;

	logic fire;
	logic done;
	logic [NUM_STRAPS-1:0] strap_reg;
	strap_cfg_t cfg;
	strap_drive_t drive_reg;
	logic debug_en_reg;
	logic [NUM_STRAPS-1:0] debug_val_reg;
	logic [NUM_STRAPS-1:0] debug_oe_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic req;
	logic wr_ctrl;
	logic wr_debug;
	logic rd_take;

	// true when the bus address selects the given register
	function automatic logic addr_is(
		input logic [15:0] adr,
		input logic [15:0] reg_adr
	);
		return adr == reg_adr;
	endfunction : addr_is

	// a byte lane keeps its old value unless its select is set
	function automatic logic [7:0] merge_lane(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic lane_en
	);
		return lane_en ? new_val : old_val;
	endfunction : merge_lane

	// status layout: raw straps above the six decoded flags
	function automatic logic [31:0] status_word(
		input strap_cfg_t c,
		input logic [NUM_STRAPS-1:0] raw
	);
		return {18'h0_0000, raw, c.factory_test, c.test_port_ok,
			c.sixth_ok, c.boot_hold, c.spread_enable, c.sampled};
	endfunction : status_word

	// pins leave high impedance only once sampling is over and
	// software has asked for debug drive
	function automatic logic drive_allowed(
		input logic sampled,
		input logic enabled
	);
		return sampled && enabled;
	endfunction : drive_allowed

	strap_delay u_delay (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fire_o(fire),
		.done_o(done)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_reg <= STRAP_RESET;
		end else if (fire) begin
			strap_reg <= strap_pin_i;
		end
	end

	always_comb begin
		cfg.sampled = done;
		cfg.spread_enable = done && strap_reg[SPREAD_BIT];
		cfg.boot_hold = done && strap_reg[BOOT_BIT];
		cfg.sixth_ok = done && strap_reg[SIXTH_BIT];
		cfg.test_port_ok = !test_port_reset_n_i;
		cfg.factory_test = factory_test_enable_i;
	end

	assign spread_enable_o = cfg.spread_enable;
	assign boot_hold_o = cfg.boot_hold;
	assign straps_valid_o = done;

	always_ff @(posedge clk_i) begin
		// a debug write before sampling is remembered but not applied,
		// so an early enable cannot fight the board pulls
		if (rst_i || !drive_allowed(done, debug_en_reg)) begin
			drive_reg.pin_oe <= '0;
			drive_reg.pin_o <= '0;
		end else begin
			drive_reg.pin_oe <= debug_oe_reg;
			drive_reg.pin_o <= debug_val_reg;
		end
	end

	assign strap_pin_o = drive_reg.pin_o;
	assign strap_pin_oe = drive_reg.pin_oe;

	// the registered ack masks the request, so one access is taken once
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_ctrl = req && wb_we_i && addr_is(wb_adr_i, WB_ADDR_CTRL);
	assign wr_debug = req && wb_we_i && addr_is(wb_adr_i, WB_ADDR_DEBUG);
	assign rd_take = req && !wb_we_i;

	// ack follows the taking edge by exactly one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	// debug enable sits in byte lane 0 of the control word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			debug_en_reg <= 1'b0;
		end else if (wr_ctrl && wb_sel_i[0]) begin
			debug_en_reg <= wb_dat_i[0];
		end
	end

	// drive value in lane 0 of the debug word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			debug_val_reg <= '0;
		end else if (wr_debug) begin
			debug_val_reg <= merge_lane(debug_val_reg, wb_dat_i[7:0],
				wb_sel_i[0]);
		end
	end

	// per-pin enables in lane 1 of the debug word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			debug_oe_reg <= '0;
		end else if (wr_debug) begin
			debug_oe_reg <= merge_lane(debug_oe_reg, wb_dat_i[15:8],
				wb_sel_i[1]);
		end
	end

	// unmapped addresses read as zero but are still acknowledged
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (wb_adr_i)
			WB_ADDR_CTRL: rdata_next = {31'h0000_0000, debug_en_reg};
			WB_ADDR_STATUS: rdata_next = status_word(cfg, strap_reg);
			WB_ADDR_DEBUG: rdata_next = {16'h0000, debug_oe_reg,
				debug_val_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// read data registered so it is stable with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (rd_take) begin
			rdata_reg <= rdata_next;
		end
	end

	assign wb_dat_o = rdata_reg;
	assign wb_ack_o = ack_reg;
endmodule : reset_strap_sampler

//--- tb/strap_board.sv
// model: board pulls and reset-level straps
`timescale 1ns/1ps
module strap_board (
	input wire logic [7:0] strap_pin_o,
	input wire logic [7:0] strap_pin_oe,
	input wire logic [7:0] pull_i,
	output logic [7:0] strap_pin_i,
	output logic test_port_reset_n_i,
	output logic factory_test_enable_i
);
	assign strap_pin_i = strap_pin_oe & strap_pin_o
		| ~strap_pin_oe & (pull_i | 8'h40);
	assign test_port_reset_n_i = 1'h0;
	assign factory_test_enable_i = 1'h0;
endmodule : strap_board

//--- tb/strap_props.sv
// checker: strap sampler port properties
`timescale 1ns/1ps
module strap_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_i,
	input wire logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_oe,
	input wire logic spread_enable_o,
	input wire logic boot_hold_o,
	input wire logic straps_valid_o
);
	import strap_pkg::*;
	logic [11:0] cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt <= '0;
		else if (cnt != '1)
			cnt <= cnt + 1'h1;
	end
	property p_hiz;
		disable iff (1'h0) rst_i |=> strap_pin_oe == '0;
	endproperty
	a_hiz: assert property (p_hiz) else $error("hiz");
	property p_time;
		$rose(straps_valid_o) |-> cnt == SAMPLE_CYCLES;
	endproperty
	a_time: assert property (p_time) else $error("time");
	property p_ss;
		$rose(straps_valid_o) |-> spread_enable_o == $past(strap_pin_i[5]);
	endproperty
	a_ss: assert property (p_ss) else $error("ss");
	property p_early;
		!straps_valid_o |-> strap_pin_oe == '0;
	endproperty
	a_early: assert property (p_early) else $error("early");
	property p_boot;
		$rose(straps_valid_o) |-> boot_hold_o == $past(strap_pin_i[0]);
	endproperty
	a_boot: assert property (p_boot) else $error("boot");
	property p_hold;
		straps_valid_o |=> straps_valid_o
			&& $stable({spread_enable_o, boot_hold_o});
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	cover property ($rose(straps_valid_o));
	cover property ($rose(boot_hold_o));
	cover property (strap_pin_oe != '0);
endmodule : strap_props
bind reset_strap_sampler strap_props u_strap_props (.*);

//--- tb/tb_top.sv
// bench: strap sampling and debug drive
`timescale 1ns/1ps
module tb_top;
	import strap_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0, wb_ack_o, spread_enable_o, boot_hold_o;
	logic straps_valid_o, test_port_reset_n_i, factory_test_enable_i;
	logic [7:0] strap_pin_i, strap_pin_o, strap_pin_oe, pull_i = 8'h00;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [3:0] wb_sel_i = 4'hf;
	int err_total, tests_run, n;
	reset_strap_sampler u_reset_strap_sampler (.*);
	strap_board u_strap_board (.*);
	always #5 clk_i = ~clk_i;
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask : ck
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		if (wb_ack_o !== 1'h1)
			err_total++;
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		repeat (2) @(posedge clk_i);
	endtask : wb
	task automatic boot(input logic [7:0] p);
		pull_i <= p;
		rst_i <= 1'h1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
	endtask : boot
	task automatic t_sample(input logic [7:0] p);
		boot(p);
		n = 0;
		while (straps_valid_o !== 1'h1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		ck(n, SAMPLE_CYCLES + 1);
		ck(spread_enable_o, p[5]);
		ck(boot_hold_o, p[0]);
		wb(1'h0, WB_ADDR_STATUS, 32'h0);
		ck(q, {p | 8'h40, 3'h3, p[0], p[5], 1'h1});
		pull_i <= ~p;
		repeat (3) @(posedge clk_i);
		ck({spread_enable_o, boot_hold_o}, {p[5], p[0]});
	endtask : t_sample
	task automatic t_debug;
		boot(8'h00);
		wb(1'h1, WB_ADDR_CTRL, 32'h1);
		ck(strap_pin_oe, 8'h00);
		repeat (160) @(posedge clk_i);
		wb(1'h1, WB_ADDR_DEBUG, 32'h0000_ff5a);
		ck({strap_pin_oe, strap_pin_o}, 16'hff5a);
		wb(1'h0, 16'h0010, 32'h0);
		ck(q, 32'h0);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		ck(strap_pin_oe, 8'h00);
	endtask : t_debug
	task automatic tally_and_finish;
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		t_sample(8'h20);
		t_sample(8'h01);
		t_debug;
		tally_and_finish;
	end
	initial begin
		#100000;
		err_total++;
		tally_and_finish;
	end
endmodule : tb_top
